// file: rpdo_pkg.sv
package rpdo_pkg;

    localparam int NREG = 7;
    localparam int LVL_W = 3;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_BUCK1 = 8'h5F;
    localparam logic [7:0] IDX_BUCK2 = 8'h60;
    localparam logic [7:0] IDX_BUCK3 = 8'h61;
    localparam logic [7:0] IDX_LINEAR1 = 8'h62;
    localparam logic [7:0] IDX_LINEAR2 = 8'h63;
    localparam logic [7:0] IDX_LINEAR3 = 8'h64;
    localparam logic [7:0] IDX_MEMREF = 8'h65;
    localparam logic [7:0] IDX_STATUS = 8'h66;

    // any_off_order field position
    localparam int ORD_LSB = 0;
    localparam int ORD_MSB = 2;

    // status register layout
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LVL_LSB = 4;
    localparam int STAT_EN_LSB = 8;

    localparam logic [NREG-1:0] EN_RST = 7'h00;
    localparam logic [NREG-1:0] EN_ALL = 7'h7F;
    localparam logic [LVL_W-1:0] LVL_TOP = 3'h7;
    localparam logic [LVL_W-1:0] LVL_RST = 3'h0;

    // slot code returned by the address decoder
    localparam logic [3:0] SLOT_STATUS = 4'h7;
    localparam logic [3:0] SLOT_NONE = 4'hF;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // spacing between off steps
    localparam int CLK_MHZ = 125;
    localparam int STEP_NS = 2000;
    localparam int STEP_CYC = (STEP_NS * CLK_MHZ) / 1000;
    localparam int CNT_W = 12;

    typedef enum logic [1:0] {
        RPDO_IDLE,
        RPDO_STEP,
        RPDO_WAIT
    } rpdo_state_t;

endpackage

// file: rpdo_match_if.sv
`timescale 1ns/100ps
interface rpdo_match_if;
    import rpdo_pkg::*;
    logic [NREG-1:0][LVL_W-1:0] order;
    logic [LVL_W-1:0] level;
    logic [NREG-1:0] hit;
    logic all_zero;
    modport mgr (output order, output level, input hit, input all_zero);
    modport unit (input order, input level, output hit, output all_zero);
endinterface

// file: rpdo_match.sv
`timescale 1ns/100ps
module rpdo_match
    import rpdo_pkg::*;
(
    rpdo_match_if.unit mi // orders in, hit mask out
);

    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1)
        begin : g_hit
            // equal orders hit on the same level and drop together
            assign mi.hit[g] = (mi.order[g] == mi.level);
        end
    endgenerate

    assign mi.all_zero = (mi.order == '0);

endmodule // rpdo_match

// file: rpdo_top.sv
`timescale 1ns/100ps
// Summary of operation
// - each regulator has its own 3-bit off order in bits 2 to 0
// - after reset each off order equals that regulator's on order, taken from fuses or from the test source
// - on power-down, regulators go off from highest order value downward
// - host may rewrite off orders only while system is on; writes are used
// - on order comes only from fuses or test source, never from bus
// - all off orders zero: skip stepping, switch every regulator off at once
// - bits 31 to 3 of each off order register have no function
module rpdo_top
    import rpdo_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic ref_clk_i, // 125 MHz
    input wire logic sys_rst_i, // sync, active high
    input wire logic [NREG*LVL_W-1:0] fuse_order_i, // fused on orders
    input wire logic [NREG*LVL_W-1:0] test_order_i, // test on orders
    input wire logic test_config_source_i, // pick test orders
    input wire logic sys_on_i, // system in an on state
    input wire logic power_on_i, // pulse: all regulators on
    input wire logic pwrdn_req_i, // pulse: start power-down
    output logic [NREG-1:0] reg_en_o, // regulator enables
    output logic busy_o, // power-down under way
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i, // write address
    input wire logic s_axi_awvalid_i, // write address valid
    output logic s_axi_awready_o, // write address ready
    input wire logic [31:0] s_axi_wdata_i, // write data
    input wire logic [3:0] s_axi_wstrb_i, // write strobes
    input wire logic s_axi_wvalid_i, // write data valid
    output logic s_axi_wready_o, // write data ready
    output logic [1:0] s_axi_bresp_o, // write response
    output logic s_axi_bvalid_o, // write response valid
    input wire logic s_axi_bready_i, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr_i, // read address
    input wire logic s_axi_arvalid_i, // read address valid
    output logic s_axi_arready_o, // read address ready
    output logic [31:0] s_axi_rdata_o, // read data
    output logic [1:0] s_axi_rresp_o, // read response
    output logic s_axi_rvalid_o, // read data valid
    input wire logic s_axi_rready_i // read data ready
);

    function automatic logic [3:0] dec_slot(input logic [ADDR_W-1:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        dec_slot = SLOT_NONE;
        if (a[1:0] == 2'h0 && a[ADDR_W-1:10] == '0)
        begin
            if (idx >= IDX_BUCK1 && idx <= IDX_MEMREF)
                dec_slot = 4'(idx - IDX_BUCK1);
            else if (idx == IDX_STATUS)
                dec_slot = SLOT_STATUS;
        end
    endfunction

    rpdo_match_if mi ();
    rpdo_match u_match (.mi(mi));

    logic [NREG-1:0][LVL_W-1:0] ord_r, ord_nxt;
    logic [NREG*LVL_W-1:0] on_src;
    rpdo_state_t st_r, st_nxt;
    logic [LVL_W-1:0] lvl_r, lvl_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [NREG-1:0] en_r, en_nxt;
    logic busy_r, busy_nxt;
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic wstrb0_r, wstrb0_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic wr_fire, wr_ok;
    logic [3:0] wr_slot, rd_slot;

    assign mi.order = ord_r;
    assign mi.level = lvl_r;

    // on orders are never stored here, so the bus cannot reach them
    assign on_src = test_config_source_i ? test_order_i : fuse_order_i;

    assign wr_slot = dec_slot(awaddr_r);
    assign rd_slot = dec_slot(s_axi_araddr_i);
    assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
    // refused outside the on states; status is read only
    assign wr_ok = sys_on_i && wr_slot < SLOT_STATUS;

    // order registers
    always_comb
    begin
        ord_nxt = ord_r;
        if (wr_fire && wr_ok && wstrb0_r)
            ord_nxt[wr_slot[2:0]] = wdata_r[ORD_MSB:ORD_LSB];
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            ord_r <= on_src;
        else
            ord_r <= ord_nxt;
    end

    // sequencer
    always_comb
    begin
        st_nxt = st_r;
        lvl_nxt = lvl_r;
        cnt_nxt = cnt_r;
        en_nxt = en_r;
        case (st_r)
            RPDO_IDLE:
            begin
                if (pwrdn_req_i)
                begin
                    if (mi.all_zero)
                        en_nxt = '0;
                    else
                    begin
                        st_nxt = RPDO_STEP;
                        lvl_nxt = LVL_TOP;
                    end
                end
                else if (power_on_i)
                    en_nxt = EN_ALL;
            end
            RPDO_STEP:
            begin
                en_nxt = en_r & ~mi.hit;
                if (lvl_r == LVL_RST)
                    st_nxt = RPDO_IDLE;
                else
                begin
                    st_nxt = RPDO_WAIT;
                    cnt_nxt = CNT_W'(STEP_CYC - 1);
                end
            end
            RPDO_WAIT:
            begin
                if (cnt_r == '0)
                begin
                    st_nxt = RPDO_STEP;
                    lvl_nxt = lvl_r - 3'h1;
                end
                else
                    cnt_nxt = cnt_r - 12'h001;
            end
            default:
                st_nxt = RPDO_IDLE;
        endcase
        busy_nxt = (st_nxt != RPDO_IDLE);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            st_r <= RPDO_IDLE;
            lvl_r <= LVL_RST;
            cnt_r <= '0;
            en_r <= EN_RST;
            busy_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            lvl_r <= lvl_nxt;
            cnt_r <= cnt_nxt;
            en_r <= en_nxt;
            busy_r <= busy_nxt;
        end
    end

    // bus slave: one write and one read at a time
    always_comb
    begin
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb0_nxt = wstrb0_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_awvalid_i && awready_r)
        begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && wready_r)
        begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata_i;
            wstrb0_nxt = s_axi_wstrb_i[0];
        end
        if (wr_fire)
        begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (bvalid_r && s_axi_bready_i)
            bvalid_nxt = 1'b0;
        awready_nxt = !aw_got_nxt && !bvalid_nxt;
        wready_nxt = !w_got_nxt && !bvalid_nxt;
        if (s_axi_arvalid_i && arready_r)
        begin
            arready_nxt = 1'b0;
            rvalid_nxt = 1'b1;
            rdata_nxt = '0; // unused bits read zero
            rresp_nxt = RESP_OKAY;
            if (rd_slot < SLOT_STATUS)
                rdata_nxt[ORD_MSB:ORD_LSB] = ord_r[rd_slot[2:0]];
            else if (rd_slot == SLOT_STATUS)
            begin
                rdata_nxt[STAT_BUSY_BIT] = busy_r;
                rdata_nxt[STAT_LVL_LSB +: LVL_W] = lvl_r;
                rdata_nxt[STAT_EN_LSB +: NREG] = en_r;
            end
            else
                rresp_nxt = RESP_SLVERR;
        end
        if (rvalid_r && s_axi_rready_i)
        begin
            rvalid_nxt = 1'b0;
        end
        // address ready only while no read data waits
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb0_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end
        else
        begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb0_r <= wstrb0_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign reg_en_o = en_r;
    assign busy_o = busy_r;
    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o = wready_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;

    chk_reset_mirror: assert property (
        @(posedge ref_clk_i) $fell(sys_rst_i) |-> ord_r == $past(on_src))
        else $error("off orders not loaded from on orders at reset");

    chk_start_top: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        st_r == RPDO_IDLE && pwrdn_req_i && !mi.all_zero
        |=> st_r == RPDO_STEP && lvl_r == LVL_TOP)
        else $error("power-down did not start at top level");

    chk_step_spacing: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        st_r == RPDO_STEP && lvl_r != LVL_RST
        |=> st_r == RPDO_WAIT && cnt_r == CNT_W'(STEP_CYC - 1))
        else $error("step spacing wrong");

    chk_step_descend: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        st_r == RPDO_WAIT && cnt_r == '0
        |=> st_r == RPDO_STEP && lvl_r == $past(lvl_r) - 3'h1)
        else $error("level order wrong");

    chk_write_used: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        wr_fire && sys_on_i && wr_slot == 4'h0 && wstrb0_r
        |=> ord_r[0] == $past(wdata_r[2:0]) && bvalid_r
        && bresp_r == RESP_OKAY)
        else $error("on-state write not applied");

    chk_write_block: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        wr_fire && !sys_on_i |=> $stable(ord_r) && bresp_r == RESP_SLVERR)
        else $error("write outside on state changed an order");

    chk_all_off: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        st_r == RPDO_IDLE && pwrdn_req_i && mi.all_zero
        |=> en_r == '0 && st_r == RPDO_IDLE)
        else $error("all-zero orders did not switch all off at once");

    chk_upper_zero: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        s_axi_arvalid_i && arready_r && rd_slot < SLOT_STATUS
        |=> rdata_r[31:3] == '0 && rdata_r[2:0] == $past(ord_r[0])
        || $past(rd_slot) != 4'h0)
        else $error("off order read shows unused bits");

    chk_same_step: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        st_r == RPDO_STEP |=> (en_r & $past(mi.hit)) == '0
        && (en_r | $past(mi.hit)) == ($past(en_r) | $past(mi.hit)))
        else $error("equal orders not switched off together");

endmodule // rpdo_top

// file: rpdo_host_model.sv
`timescale 1ns/100ps
module rpdo_host_model
    import rpdo_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic clk_i, // bus clock
    output logic [ADDR_W-1:0] awaddr_o = '0, // write address
    output logic awvalid_o = 1'b0, // write address valid
    input wire logic awready_i, // write address ready
    output logic [31:0] wdata_o = '0, // write data
    output logic [3:0] wstrb_o = 4'h0, // write strobes
    output logic wvalid_o = 1'b0, // write data valid
    input wire logic wready_i, // write data ready
    input wire logic [1:0] bresp_i, // write response
    input wire logic bvalid_i, // write response valid
    output logic bready_o = 1'b0, // write response ready
    output logic [ADDR_W-1:0] araddr_o = '0, // read address
    output logic arvalid_o = 1'b0, // read address valid
    input wire logic arready_i, // read address ready
    input wire logic [31:0] rdata_i, // read data
    input wire logic [1:0] rresp_i, // read response
    input wire logic rvalid_i, // read data valid
    output logic rready_o = 1'b0 // read data ready
);
    // the bench decides whether the system is on when it writes
    task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                      output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk_i);
        awaddr_o <= ADDR_W'({idx, 2'b00});
        awvalid_o <= 1'b1;
        wdata_o <= d;
        wstrb_o <= 4'hF;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (awready_i && !aw_done)
            begin
                aw_done = 1'b1;
                awvalid_o <= 1'b0;
            end
            if (wready_i && !w_done)
            begin
                w_done = 1'b1;
                wvalid_o <= 1'b0;
            end
        end while (!(aw_done && w_done));
        do @(posedge clk_i); while (!bvalid_i);
        resp = bresp_i;
        bready_o <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                      output logic [1:0] resp);
        @(posedge clk_i);
        araddr_o <= ADDR_W'({idx, 2'b00});
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        do @(posedge clk_i); while (!arready_i);
        arvalid_o <= 1'b0;
        do @(posedge clk_i); while (!rvalid_i);
        d = rdata_i;
        resp = rresp_i;
        rready_o <= 1'b0;
    endtask
endmodule // rpdo_host_model

// file: testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module testbench;
    import rpdo_pkg::*;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [20:0] fuse_order_i = {3'h2, 3'h0, 3'h1, 3'h5, 3'h3, 3'h3, 3'h7};
    logic [20:0] test_order_i = {3'h6, 3'h4, 3'h2, 3'h0, 3'h1, 3'h3, 3'h5};
    logic [20:0] new_order = {3'h0, 3'h7, 3'h2, 3'h2, 3'h6, 3'h1, 3'h4};
    logic test_config_source_i = 1'b0;
    logic sys_on_i = 1'b1;
    logic power_on_i = 1'b0;
    logic pwrdn_req_i = 1'b0;
    logic [NREG-1:0] reg_en_o;
    logic busy_o;
    logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rdat;
    logic [3:0] s_axi_wstrb_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
    logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
    logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
    logic s_axi_rvalid_o, s_axi_rready_i;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;

    always #4 ref_clk_i = ~ref_clk_i;

    rpdo_top dut (.ref_clk_i, .sys_rst_i, .fuse_order_i, .test_order_i,
        .test_config_source_i, .sys_on_i, .power_on_i, .pwrdn_req_i,
        .reg_en_o, .busy_o, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
        .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i);

    rpdo_host_model host (.clk_i(ref_clk_i), .awaddr_o(s_axi_awaddr_i),
        .awvalid_o(s_axi_awvalid_i), .awready_i(s_axi_awready_o),
        .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i),
        .wvalid_o(s_axi_wvalid_i), .wready_i(s_axi_wready_o),
        .bresp_i(s_axi_bresp_o), .bvalid_i(s_axi_bvalid_o),
        .bready_o(s_axi_bready_i), .araddr_o(s_axi_araddr_i),
        .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o),
        .rdata_i(s_axi_rdata_o), .rresp_i(s_axi_rresp_o),
        .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i));

    task automatic end_sim;
        if (n_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic rd_chk(input int k, input logic [31:0] e,
                          input logic [1:0] er);
        host.rd(8'(k), rdat, resp);
        `CHK("rdata", e, rdat)
        `CHK("rresp", er, resp)
    endtask

    task automatic wr_chk(input int k, input logic [31:0] d,
                          input logic [1:0] er);
        host.wr(8'(k), d, resp);
        `CHK("bresp", er, resp)
    endtask

    task automatic do_reset;
        @(posedge ref_clk_i);
        sys_rst_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
    endtask

    // pulse power-on then power-down; request taken at the third edge
    task automatic start_pd;
        @(posedge ref_clk_i);
        power_on_i <= 1'b1;
        @(posedge ref_clk_i);
        power_on_i <= 1'b0;
        pwrdn_req_i <= 1'b1;
        @(posedge ref_clk_i);
        pwrdn_req_i <= 1'b0;
    endtask

    // expected enables: only regulators below the level just passed stay on
    task automatic run_seq(input logic [20:0] o);
        logic [NREG-1:0] m;
        start_pd();
        #1 `CHK("en_all", EN_ALL, reg_en_o)
        for (int l = 7; l >= 0; l--)
        begin
            repeat ((l == 7) ? 2 : 251) @(posedge ref_clk_i);
            for (int k = 0; k < NREG; k++)
                m[k] = o[3*k +: 3] < l;
            #1 `CHK("reg_en", m, reg_en_o)
            `CHK("busy", l != 0, busy_o)
        end
    endtask

    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            end_sim();
        end
    end

    initial
    begin
        do_reset();
        for (int k = 0; k < NREG; k++)
            rd_chk(IDX_BUCK1 + k, {29'h0, fuse_order_i[3*k +: 3]},
                RESP_OKAY);
        run_seq(fuse_order_i);
        for (int k = 0; k < NREG; k++)
            wr_chk(IDX_BUCK1 + k, {29'h1FFFFFFF, new_order[3*k +: 3]},
                RESP_OKAY);
        for (int k = 0; k < NREG; k++)
            rd_chk(IDX_BUCK1 + k, {29'h0, new_order[3*k +: 3]},
                RESP_OKAY);
        run_seq(new_order);
        @(posedge ref_clk_i);
        sys_on_i <= 1'b0;
        wr_chk(IDX_BUCK2, 32'h5, RESP_SLVERR);
        rd_chk(IDX_BUCK2, {29'h0, new_order[5:3]}, RESP_OKAY);
        @(posedge ref_clk_i);
        sys_on_i <= 1'b1;
        rd_chk(8'h10, 32'h0, RESP_SLVERR);
        wr_chk(IDX_STATUS, 32'h0, RESP_SLVERR);
        for (int k = 0; k < NREG; k++)
            wr_chk(IDX_BUCK1 + k, 32'h0, RESP_OKAY);
        start_pd();
        @(posedge ref_clk_i);
        #1 `CHK("en_zero", EN_RST, reg_en_o)
        `CHK("busy_zero", 1'b0, busy_o)
        rd_chk(IDX_STATUS, 32'h0, RESP_OKAY);
        @(posedge ref_clk_i);
        test_config_source_i <= 1'b1;
        do_reset();
        for (int k = 0; k < NREG; k++)
            rd_chk(IDX_BUCK1 + k, {29'h0, test_order_i[3*k +: 3]},
                RESP_OKAY);
        end_sim();
    end
endmodule // testbench
